// ### rtl/iprb_consts.vh
`ifndef IPRB_CONSTS_VH
`define IPRB_CONSTS_VH
// How it works
// - three-bit field, 111 highest, 000 disables
// - every field resets to binary 100
// - unimplemented bits read zero, hold nothing
// - encoder two 14-12, pwm secondary 6-4
// - adc pairs ten, nine, eight at 14/10/6
// - adc pair twelve in bits 6-4
// - pwm generators two, one at 14/10
// - pwm generators six to three, four fields
// - comparator two, pwm nine to seven
// - comparators four, three in low byte
// - adc pairs one, zero at 14/10

// ----------------------------------------
// register indices (word address)
// ----------------------------------------
`define IPRB_ADDR_W 3
`define IPRB_IDX_ENC_PWMSEC 3'h0
`define IPRB_IDX_ADC_8_10 3'h1
`define IPRB_IDX_ADC_12 3'h2
`define IPRB_IDX_PWM_1_2 3'h3
`define IPRB_IDX_PWM_3_6 3'h4
`define IPRB_IDX_CMP2_PWM_7_9 3'h5
`define IPRB_IDX_CMP_3_4 3'h6
`define IPRB_IDX_ADC_0_1 3'h7

// ----------------------------------------
// field layout
// ----------------------------------------
`define IPRB_DATA_W 16
`define IPRB_PRIO_W 3
`define IPRB_PRIO_RST 3'h4
`define IPRB_F3_HI 14
`define IPRB_F3_LO 12
`define IPRB_F2_HI 10
`define IPRB_F2_LO 8
`define IPRB_F1_HI 6
`define IPRB_F1_LO 4
`define IPRB_F0_HI 2
`define IPRB_F0_LO 0
`define IPRB_ZERO16 16'h0000
`endif

// ### rtl/iprb_top.v
`timescale 1ns/100ps
`include "iprb_consts.vh"

module iprb_top (
  input wire clk_i,
  input wire arst_n_i,
  input wire [`IPRB_ADDR_W-1:0] addr_i,
  input wire [`IPRB_DATA_W-1:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [`IPRB_DATA_W-1:0] rdata_o,
  output reg [2:0] encoder_two_priority_o,
  output reg [2:0] pwm_secondary_match_priority_o,
  output reg [2:0] adc_pair_ten_priority_o,
  output reg [2:0] adc_pair_nine_priority_o,
  output reg [2:0] adc_pair_eight_priority_o,
  output reg [2:0] adc_pair_twelve_priority_o,
  output reg [2:0] pwm_gen_two_priority_o,
  output reg [2:0] pwm_gen_one_priority_o,
  output reg [2:0] pwm_gen_six_priority_o,
  output reg [2:0] pwm_gen_five_priority_o,
  output reg [2:0] pwm_gen_four_priority_o,
  output reg [2:0] pwm_gen_three_priority_o,
  output reg [2:0] comparator_two_priority_o,
  output reg [2:0] pwm_gen_nine_priority_o,
  output reg [2:0] pwm_gen_eight_priority_o,
  output reg [2:0] pwm_gen_seven_priority_o,
  output reg [2:0] comparator_four_priority_o,
  output reg [2:0] comparator_three_priority_o,
  output reg [2:0] adc_pair_one_priority_o,
  output reg [2:0] adc_pair_zero_priority_o
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // one strobe decoder shared by all eight registers
  // every index is mapped, so no access is ever refused
  function strobe_hit;
    input strobe;
    input [`IPRB_ADDR_W-1:0] addr;
    input [`IPRB_ADDR_W-1:0] idx;
    begin
      strobe_hit = strobe && (addr == idx);
    end
  endfunction

  // priority field taken out of a data word at its lowest bit
  function [`IPRB_PRIO_W-1:0] field_of;
    input [`IPRB_DATA_W-1:0] word;
    input integer lo;
    begin
      field_of = word[lo +: `IPRB_PRIO_W];
    end
  endfunction

  // read word holding one field; all other bits are zero, with no flop behind them
  function [`IPRB_DATA_W-1:0] field_at;
    input [`IPRB_PRIO_W-1:0] prio;
    input integer lo;
    begin
      field_at = `IPRB_ZERO16;
      field_at[lo +: `IPRB_PRIO_W] = prio;
    end
  endfunction

  // ----------------------------------------
  // prio_encoder2_pwm_secondary, index 0
  // ----------------------------------------
  wire wr_enc = strobe_hit(wr_i, addr_i, `IPRB_IDX_ENC_PWMSEC);
  reg [`IPRB_PRIO_W-1:0] encoder_two_priority_d;
  reg [`IPRB_PRIO_W-1:0] pwm_secondary_match_priority_d;
  wire [`IPRB_DATA_W-1:0] img_enc;

  // code 000 is stored like any other; the arbiter treats it as disabled
  always @* begin
    encoder_two_priority_d = encoder_two_priority_o;
    pwm_secondary_match_priority_d = pwm_secondary_match_priority_o;
    if (wr_enc) begin
      encoder_two_priority_d = field_of(wdata_i, `IPRB_F3_LO);
      pwm_secondary_match_priority_d = field_of(wdata_i, `IPRB_F1_LO);
    end
  end

  assign img_enc = field_at(encoder_two_priority_o, `IPRB_F3_LO)
    | field_at(pwm_secondary_match_priority_o, `IPRB_F1_LO);

  // ----------------------------------------
  // prio_adc_pairs_8_to_10, index 1
  // ----------------------------------------
  wire wr_a810 = strobe_hit(wr_i, addr_i, `IPRB_IDX_ADC_8_10);
  reg [`IPRB_PRIO_W-1:0] adc_pair_ten_priority_d;
  reg [`IPRB_PRIO_W-1:0] adc_pair_nine_priority_d;
  reg [`IPRB_PRIO_W-1:0] adc_pair_eight_priority_d;
  wire [`IPRB_DATA_W-1:0] img_a810;

  always @* begin
    adc_pair_ten_priority_d = adc_pair_ten_priority_o;
    adc_pair_nine_priority_d = adc_pair_nine_priority_o;
    adc_pair_eight_priority_d = adc_pair_eight_priority_o;
    if (wr_a810) begin
      adc_pair_ten_priority_d = field_of(wdata_i, `IPRB_F3_LO);
      adc_pair_nine_priority_d = field_of(wdata_i, `IPRB_F2_LO);
      adc_pair_eight_priority_d = field_of(wdata_i, `IPRB_F1_LO);
    end
  end

  assign img_a810 = field_at(adc_pair_ten_priority_o, `IPRB_F3_LO)
    | field_at(adc_pair_nine_priority_o, `IPRB_F2_LO)
    | field_at(adc_pair_eight_priority_o, `IPRB_F1_LO);

  // ----------------------------------------
  // prio_adc_pair_12, index 2
  // ----------------------------------------
  wire wr_a12 = strobe_hit(wr_i, addr_i, `IPRB_IDX_ADC_12);
  reg [`IPRB_PRIO_W-1:0] adc_pair_twelve_priority_d;
  wire [`IPRB_DATA_W-1:0] img_a12;

  always @* begin
    adc_pair_twelve_priority_d = adc_pair_twelve_priority_o;
    if (wr_a12) begin
      adc_pair_twelve_priority_d = field_of(wdata_i, `IPRB_F1_LO);
    end
  end

  assign img_a12 = field_at(adc_pair_twelve_priority_o, `IPRB_F1_LO);

  // ----------------------------------------
  // prio_pwm_1_2, index 3
  // ----------------------------------------
  // the low byte has no fields and reads zero
  wire wr_p12 = strobe_hit(wr_i, addr_i, `IPRB_IDX_PWM_1_2);
  reg [`IPRB_PRIO_W-1:0] pwm_gen_two_priority_d;
  reg [`IPRB_PRIO_W-1:0] pwm_gen_one_priority_d;
  wire [`IPRB_DATA_W-1:0] img_p12;

  always @* begin
    pwm_gen_two_priority_d = pwm_gen_two_priority_o;
    pwm_gen_one_priority_d = pwm_gen_one_priority_o;
    if (wr_p12) begin
      pwm_gen_two_priority_d = field_of(wdata_i, `IPRB_F3_LO);
      pwm_gen_one_priority_d = field_of(wdata_i, `IPRB_F2_LO);
    end
  end

  assign img_p12 = field_at(pwm_gen_two_priority_o, `IPRB_F3_LO)
    | field_at(pwm_gen_one_priority_o, `IPRB_F2_LO);

  // ----------------------------------------
  // prio_pwm_3_to_6, index 4
  // ----------------------------------------
  wire wr_p36 = strobe_hit(wr_i, addr_i, `IPRB_IDX_PWM_3_6);
  reg [`IPRB_PRIO_W-1:0] pwm_gen_six_priority_d;
  reg [`IPRB_PRIO_W-1:0] pwm_gen_five_priority_d;
  reg [`IPRB_PRIO_W-1:0] pwm_gen_four_priority_d;
  reg [`IPRB_PRIO_W-1:0] pwm_gen_three_priority_d;
  wire [`IPRB_DATA_W-1:0] img_p36;

  always @* begin
    pwm_gen_six_priority_d = pwm_gen_six_priority_o;
    pwm_gen_five_priority_d = pwm_gen_five_priority_o;
    pwm_gen_four_priority_d = pwm_gen_four_priority_o;
    pwm_gen_three_priority_d = pwm_gen_three_priority_o;
    if (wr_p36) begin
      pwm_gen_six_priority_d = field_of(wdata_i, `IPRB_F3_LO);
      pwm_gen_five_priority_d = field_of(wdata_i, `IPRB_F2_LO);
      pwm_gen_four_priority_d = field_of(wdata_i, `IPRB_F1_LO);
      pwm_gen_three_priority_d = field_of(wdata_i, `IPRB_F0_LO);
    end
  end

  assign img_p36 = field_at(pwm_gen_six_priority_o, `IPRB_F3_LO)
    | field_at(pwm_gen_five_priority_o, `IPRB_F2_LO)
    | field_at(pwm_gen_four_priority_o, `IPRB_F1_LO)
    | field_at(pwm_gen_three_priority_o, `IPRB_F0_LO);

  // ----------------------------------------
  // prio_comparator2_pwm_7_to_9, index 5
  // ----------------------------------------
  wire wr_c2p = strobe_hit(wr_i, addr_i, `IPRB_IDX_CMP2_PWM_7_9);
  reg [`IPRB_PRIO_W-1:0] comparator_two_priority_d;
  reg [`IPRB_PRIO_W-1:0] pwm_gen_nine_priority_d;
  reg [`IPRB_PRIO_W-1:0] pwm_gen_eight_priority_d;
  reg [`IPRB_PRIO_W-1:0] pwm_gen_seven_priority_d;
  wire [`IPRB_DATA_W-1:0] img_c2p;

  always @* begin
    comparator_two_priority_d = comparator_two_priority_o;
    pwm_gen_nine_priority_d = pwm_gen_nine_priority_o;
    pwm_gen_eight_priority_d = pwm_gen_eight_priority_o;
    pwm_gen_seven_priority_d = pwm_gen_seven_priority_o;
    if (wr_c2p) begin
      comparator_two_priority_d = field_of(wdata_i, `IPRB_F3_LO);
      pwm_gen_nine_priority_d = field_of(wdata_i, `IPRB_F2_LO);
      pwm_gen_eight_priority_d = field_of(wdata_i, `IPRB_F1_LO);
      pwm_gen_seven_priority_d = field_of(wdata_i, `IPRB_F0_LO);
    end
  end

  assign img_c2p = field_at(comparator_two_priority_o, `IPRB_F3_LO)
    | field_at(pwm_gen_nine_priority_o, `IPRB_F2_LO)
    | field_at(pwm_gen_eight_priority_o, `IPRB_F1_LO)
    | field_at(pwm_gen_seven_priority_o, `IPRB_F0_LO);

  // ----------------------------------------
  // prio_comparators_3_4, index 6
  // ----------------------------------------
  // the upper byte has no fields and reads zero
  wire wr_c34 = strobe_hit(wr_i, addr_i, `IPRB_IDX_CMP_3_4);
  reg [`IPRB_PRIO_W-1:0] comparator_four_priority_d;
  reg [`IPRB_PRIO_W-1:0] comparator_three_priority_d;
  wire [`IPRB_DATA_W-1:0] img_c34;

  always @* begin
    comparator_four_priority_d = comparator_four_priority_o;
    comparator_three_priority_d = comparator_three_priority_o;
    if (wr_c34) begin
      comparator_four_priority_d = field_of(wdata_i, `IPRB_F1_LO);
      comparator_three_priority_d = field_of(wdata_i, `IPRB_F0_LO);
    end
  end

  assign img_c34 = field_at(comparator_four_priority_o, `IPRB_F1_LO)
    | field_at(comparator_three_priority_o, `IPRB_F0_LO);

  // ----------------------------------------
  // prio_adc_pairs_0_1, index 7
  // ----------------------------------------
  wire wr_a01 = strobe_hit(wr_i, addr_i, `IPRB_IDX_ADC_0_1);
  reg [`IPRB_PRIO_W-1:0] adc_pair_one_priority_d;
  reg [`IPRB_PRIO_W-1:0] adc_pair_zero_priority_d;
  wire [`IPRB_DATA_W-1:0] img_a01;

  always @* begin
    adc_pair_one_priority_d = adc_pair_one_priority_o;
    adc_pair_zero_priority_d = adc_pair_zero_priority_o;
    if (wr_a01) begin
      adc_pair_one_priority_d = field_of(wdata_i, `IPRB_F3_LO);
      adc_pair_zero_priority_d = field_of(wdata_i, `IPRB_F2_LO);
    end
  end

  assign img_a01 = field_at(adc_pair_one_priority_o, `IPRB_F3_LO)
    | field_at(adc_pair_zero_priority_o, `IPRB_F2_LO);

  // ----------------------------------------
  // field registers
  // ----------------------------------------
  // the outputs are these flops, so arbitration sees a write on the very next cycle
  // reset puts every listed source at level four
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      encoder_two_priority_o <= `IPRB_PRIO_RST;
      pwm_secondary_match_priority_o <= `IPRB_PRIO_RST;
      adc_pair_ten_priority_o <= `IPRB_PRIO_RST;
      adc_pair_nine_priority_o <= `IPRB_PRIO_RST;
      adc_pair_eight_priority_o <= `IPRB_PRIO_RST;
      adc_pair_twelve_priority_o <= `IPRB_PRIO_RST;
      pwm_gen_two_priority_o <= `IPRB_PRIO_RST;
      pwm_gen_one_priority_o <= `IPRB_PRIO_RST;
      pwm_gen_six_priority_o <= `IPRB_PRIO_RST;
      pwm_gen_five_priority_o <= `IPRB_PRIO_RST;
      pwm_gen_four_priority_o <= `IPRB_PRIO_RST;
      pwm_gen_three_priority_o <= `IPRB_PRIO_RST;
      comparator_two_priority_o <= `IPRB_PRIO_RST;
      pwm_gen_nine_priority_o <= `IPRB_PRIO_RST;
      pwm_gen_eight_priority_o <= `IPRB_PRIO_RST;
      pwm_gen_seven_priority_o <= `IPRB_PRIO_RST;
      comparator_four_priority_o <= `IPRB_PRIO_RST;
      comparator_three_priority_o <= `IPRB_PRIO_RST;
      adc_pair_one_priority_o <= `IPRB_PRIO_RST;
      adc_pair_zero_priority_o <= `IPRB_PRIO_RST;
    end else begin
      encoder_two_priority_o <= encoder_two_priority_d;
      pwm_secondary_match_priority_o <= pwm_secondary_match_priority_d;
      adc_pair_ten_priority_o <= adc_pair_ten_priority_d;
      adc_pair_nine_priority_o <= adc_pair_nine_priority_d;
      adc_pair_eight_priority_o <= adc_pair_eight_priority_d;
      adc_pair_twelve_priority_o <= adc_pair_twelve_priority_d;
      pwm_gen_two_priority_o <= pwm_gen_two_priority_d;
      pwm_gen_one_priority_o <= pwm_gen_one_priority_d;
      pwm_gen_six_priority_o <= pwm_gen_six_priority_d;
      pwm_gen_five_priority_o <= pwm_gen_five_priority_d;
      pwm_gen_four_priority_o <= pwm_gen_four_priority_d;
      pwm_gen_three_priority_o <= pwm_gen_three_priority_d;
      comparator_two_priority_o <= comparator_two_priority_d;
      pwm_gen_nine_priority_o <= pwm_gen_nine_priority_d;
      pwm_gen_eight_priority_o <= pwm_gen_eight_priority_d;
      pwm_gen_seven_priority_o <= pwm_gen_seven_priority_d;
      comparator_four_priority_o <= comparator_four_priority_d;
      comparator_three_priority_o <= comparator_three_priority_d;
      adc_pair_one_priority_o <= adc_pair_one_priority_d;
      adc_pair_zero_priority_o <= adc_pair_zero_priority_d;
    end
  end

  // ----------------------------------------
  // read-back
  // ----------------------------------------
  // a read that meets a write in the same cycle returns the old fields
  reg [`IPRB_DATA_W-1:0] rdata_d;

  always @* begin
    case (addr_i)
      `IPRB_IDX_ENC_PWMSEC: rdata_d = img_enc;
      `IPRB_IDX_ADC_8_10: rdata_d = img_a810;
      `IPRB_IDX_ADC_12: rdata_d = img_a12;
      `IPRB_IDX_PWM_1_2: rdata_d = img_p12;
      `IPRB_IDX_PWM_3_6: rdata_d = img_p36;
      `IPRB_IDX_CMP2_PWM_7_9: rdata_d = img_c2p;
      `IPRB_IDX_CMP_3_4: rdata_d = img_c34;
      `IPRB_IDX_ADC_0_1: rdata_d = img_a01;
      default: rdata_d = `IPRB_ZERO16;
    endcase
  end

  // read data only stands in the cycle after the strobe, zero otherwise
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= `IPRB_ZERO16;
    end else if (rd_i) begin
      rdata_o <= rdata_d;
    end else begin
      rdata_o <= `IPRB_ZERO16;
    end
  end

endmodule // iprb_top

// ### sim/iprb_props.sv
`timescale 1ns/100ps
module iprb_props (
  input wire clk_i,
  input wire arst_n_i,
  input wire [2:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [15:0] rdata_o,
  input wire [2:0] encoder_two_priority_o,
  input wire [2:0] adc_pair_twelve_priority_o,
  input wire [2:0] pwm_gen_three_priority_o,
  input wire [2:0] comparator_three_priority_o
);
  // copy of the data bus, so a check can slice what the taken write carried
  logic [15:0] wd_q;
  always @(posedge clk_i) wd_q <= wdata_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  property p_enc; wr_i && addr_i == 3'h0 |=> encoder_two_priority_o == wd_q[14:12]; endproperty
  a_enc: assert property (p_enc) else $error("encoder field missed write");
  property p_adc; wr_i && addr_i == 3'h2 |=> adc_pair_twelve_priority_o == wd_q[6:4]; endproperty
  a_adc: assert property (p_adc) else $error("adc twelve field missed write");
  property p_pwm; wr_i && addr_i == 3'h4 |=> pwm_gen_three_priority_o == wd_q[2:0]; endproperty
  a_pwm: assert property (p_pwm) else $error("pwm three field missed write");
  property p_cmp; wr_i && addr_i == 3'h6 |=> comparator_three_priority_o == wd_q[2:0]; endproperty
  a_cmp: assert property (p_cmp) else $error("comparator three missed write");
  property p_hold; !(wr_i && addr_i == 3'h0) |=> $stable(encoder_two_priority_o); endproperty
  a_hold: assert property (p_hold) else $error("encoder field moved");
  property p_unimp; rd_i && addr_i == 3'h2 |=> rdata_o[15:7] == 9'h000 && rdata_o[3:0] == 4'h0;
  endproperty
  a_unimp: assert property (p_unimp) else $error("unused bits read nonzero");
  property p_back; rd_i && addr_i == 3'h6 |=> rdata_o[2:0] == comparator_three_priority_o;
  endproperty
  a_back: assert property (p_back) else $error("read differs from output");
  property p_rst; $rose(arst_n_i) |-> encoder_two_priority_o == 3'h4 && pwm_gen_three_priority_o == 3'h4;
  endproperty
  a_rst: assert property (p_rst) else $error("field not level four after reset");
endmodule // iprb_props
bind iprb_top iprb_props u_props (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .encoder_two_priority_o(encoder_two_priority_o),
  .adc_pair_twelve_priority_o(adc_pair_twelve_priority_o),
  .pwm_gen_three_priority_o(pwm_gen_three_priority_o),
  .comparator_three_priority_o(comparator_three_priority_o));

// ### sim/testbench.sv
`timescale 1ns/100ps
module testbench;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  wire [15:0] rdata_o;
  wire [59:0] prio;
  int fails = 0;
  int checks = 0;
  // implemented field bits of each register index
  logic [15:0] mask [8] = '{16'h7070, 16'h7770, 16'h0070, 16'h7700, 16'h7777, 16'h7777,
    16'h0077, 16'h7700};
  always #5 clk_i = ~clk_i;
  iprb_top uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .encoder_two_priority_o(prio[59:57]), .pwm_secondary_match_priority_o(prio[56:54]),
    .adc_pair_ten_priority_o(prio[53:51]), .adc_pair_nine_priority_o(prio[50:48]),
    .adc_pair_eight_priority_o(prio[47:45]), .adc_pair_twelve_priority_o(prio[44:42]),
    .pwm_gen_two_priority_o(prio[41:39]), .pwm_gen_one_priority_o(prio[38:36]),
    .pwm_gen_six_priority_o(prio[35:33]), .pwm_gen_five_priority_o(prio[32:30]),
    .pwm_gen_four_priority_o(prio[29:27]), .pwm_gen_three_priority_o(prio[26:24]),
    .comparator_two_priority_o(prio[23:21]), .pwm_gen_nine_priority_o(prio[20:18]),
    .pwm_gen_eight_priority_o(prio[17:15]), .pwm_gen_seven_priority_o(prio[14:12]),
    .comparator_four_priority_o(prio[11:9]), .comparator_three_priority_o(prio[8:6]),
    .adc_pair_one_priority_o(prio[5:3]), .adc_pair_zero_priority_o(prio[2:0]));
  task automatic chk(input logic [59:0] got, input logic [59:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask
  task automatic reset_check;
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    repeat (19) @(posedge clk_i);
    arst_n_i <= 1'b1;
    for (int i = 0; i < 8; i++) rd(3'(i), mask[i] & 16'h4444);
    chk(prio, {20{3'h4}});
    $display("reset test done");
  endtask
  task automatic wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    reset_check();
    for (int i = 0; i < 8; i++) begin
      wr(3'(i), 16'hFFFF);
      rd(3'(i), mask[i]);
    end
    $display("unused bits test done");
    for (int c = 0; c < 8; c++) begin
      wr(3'h4, {4{1'b0, 3'(c)}});
      rd(3'h4, {4{1'b0, 3'(c)}});
      chk(prio[35:24], {4{3'(c)}});
    end
    $display("codes test done");
    for (int i = 0; i < 8; i++) wr(3'(i), 16'h6152);
    #1 chk(prio, 60'hD71B71C6AC6AAB1);
    $display("field map test done");
    reset_check();
    wrap_up();
  end
  // the whole sequence takes well under 2000 cycles
  initial begin
    #100000;
    fails++;
    wrap_up();
  end
endmodule // testbench
